// *** logic/gpes_event.v ***
// Shared event output logic with its AXI4-Lite register slave
`default_nettype none
`include "gpes_map.vh"

// Ports 1..3 may move their hot-plug notifications onto one shared
// event line. That line leaves on pin 7 only while the pin is set to
// its alternate function, and its active level follows the polarity
// invert bit of the control register. A read-only status word shows
// which enabled ports are driving the line at the moment.

// Behaviour
// - Output active low, high when invert set
// - Enabled ports redirect notifications onto event output
// - Event drives pin 7 only in alternate mode
// - Status bit high while port signals event
// - Status never set when port not enabled
module gpes_event (
    // Clock and reset
    input  wire        core_clk,
    input  wire        arst_n,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [11:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [11:0] s_axi_araddr,
    // AXI4-Lite read data
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    // Per-port event requests from the hot-plug logic of ports 1..3
    input  wire [2:0]  port_event_req,
    // Standard notifications passed on, per port, when not redirected
    output wire [2:0]  port_notify_allow,
    // General purpose pin 7 mux select and pin driver
    input  wire        pin7_func_sel,
    input  wire        pin7_gpio_out,
    input  wire        pin7_gpio_oe,
    output wire        pin7_out,
    output wire        pin7_oe
);

    // Control register: enables and polarity invert
    reg  [3:0]  ctl_q;
    // Status register: ports currently signalling
    reg  [2:0]  sts_q;
    // Registered shared event output level
    // Held in a flop so the pin never glitches while requests settle
    reg         shared_event_output_q;
    // Write channel holding state
    reg         aw_got_q;
    reg         w_got_q;
    reg  [11:0] aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         bvalid_q;
    reg  [1:0]  bresp_q;
    // Read channel state
    reg         rvalid_q;
    reg  [31:0] rdata_q;
    reg  [1:0]  rresp_q;

    // Per-port redirect enables, port 1 in bit 0
    wire [2:0]  en_w;
    // Next status: requests of enabled ports only
    wire [2:0]  sts_d;
    // At least one enabled port is requesting
    wire        any_evt;
    // Address and data both held: commit the write
    wire        wr_fire;

    // Word decode of a byte address
    // Low two address bits are ignored: every register is one word
    function is_reg;
        input [11:0] addr;
        input [11:0] offs;
        begin
            is_reg = (addr[11:2] == offs[11:2]);
        end
    endfunction

    // Enables sit just above the invert bit in the control word
    assign en_w  = ctl_q[`GPES_CTL_EN_MSB:`GPES_CTL_EN_LSB];
    // Only enabled ports report status
    assign sts_d = port_event_req & en_w;
    // Suppress standard notifications of redirected ports
    assign port_notify_allow = port_event_req & ~en_w;
    // Combine enabled ports before polarity
    assign any_evt = |sts_d;

    // Pin 7 driven by event only in alternate mode
    // In ordinary mode the pin belongs to the general purpose output
    // logic; the event line is then simply not visible outside.
    assign pin7_out = (pin7_func_sel == `GPES_PIN_ALT) ?
                      shared_event_output_q : pin7_gpio_out;
    assign pin7_oe  = (pin7_func_sel == `GPES_PIN_ALT) ?
                      1'b1 : pin7_gpio_oe;

    // Status and event output registers
    // Both are taken from the same sum on the same edge, so the status
    // register always agrees with the event flop; read data is loaded from it one edge later.
    // Reset leaves the line at its idle level for normal polarity.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Nothing signalled, line idle
            sts_q                 <= `GPES_STS_RESET;
            shared_event_output_q <= `GPES_EVT_RESET;
        end else begin
            // Live level: no sticky bit, so nothing to clear
            sts_q <= sts_d;
            // Low when active, unless invert is set
            shared_event_output_q <= ctl_q[`GPES_CTL_INV_BIT] ?
                                     any_evt : ~any_evt;
        end
    end

    // Write side handshakes: each channel taken once, held until response
    // Address and data may come in either order; each one is parked
    // until the other arrives, and neither is taken again while the
    // response still stands, so one write at most is under way.
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready  = !w_got_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;

    // Write channel capture, register update and response
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Idle bus, control at its reset value
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `GPES_RESP_OKAY;
            ctl_q     <= `GPES_CTL_RESET;
        end else begin
            // Capture address
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            // Capture data
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q  <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            // Both present: perform write
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                if (is_reg(aw_addr_q, `GPES_CTL_OFFSET)) begin
                    // Control fields all sit in byte lane 0
                    if (w_strb_q[0])
                        ctl_q <= w_data_q[3:0];
                    bresp_q <= `GPES_RESP_OKAY;
                end else if (is_reg(aw_addr_q, `GPES_STS_OFFSET)) begin
                    // Status is read only: write ignored
                    bresp_q <= `GPES_RESP_OKAY;
                end else begin
                    // Unmapped address
                    bresp_q <= `GPES_RESP_SLVERR;
                end
            end else if (bvalid_q && s_axi_bready) begin
                // Response taken: free the write channels
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read side handshakes
    // A new address is refused while the answer stands, so read data
    // and response hold steady until the master takes them.
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Read decode and data register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // No answer pending
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `GPES_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            // Address taken: decode and load the answer
            rvalid_q <= 1'b1;
            if (is_reg(s_axi_araddr, `GPES_CTL_OFFSET)) begin
                // Control, reserved bits zero
                rdata_q <= {28'h0000000, ctl_q};
                rresp_q <= `GPES_RESP_OKAY;
            end else if (is_reg(s_axi_araddr, `GPES_STS_OFFSET)) begin
                // Status at bits 3:1, bit 0 reserved
                rdata_q <= {28'h0000000, sts_q, 1'b0};
                rresp_q <= `GPES_RESP_OKAY;
            end else begin
                // Unmapped: zero data, error
                rdata_q <= 32'h00000000;
                rresp_q <= `GPES_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            // Answer taken: free the read channel
            rvalid_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** logic/gpes_map.vh ***
// Register offsets, field positions and reset values of the event block
`ifndef GPES_MAP_VH
`define GPES_MAP_VH

// Byte offsets of the two registers
`define GPES_CTL_OFFSET      12'h450
`define GPES_STS_OFFSET      12'h454
// Control register fields
`define GPES_CTL_INV_BIT     0
`define GPES_CTL_EN_LSB      1
`define GPES_CTL_EN_MSB      3
`define GPES_CTL_RESET       4'h0
// Status register fields
`define GPES_STS_LSB         1
`define GPES_STS_MSB         3
`define GPES_STS_RESET       3'h0
// Idle level of the shared line after reset (normal polarity)
`define GPES_EVT_RESET       1'b1
// Pin 7 mux select value for alternate function
`define GPES_PIN_ALT         1'b1
// AXI responses
`define GPES_RESP_OKAY       2'h0
`define GPES_RESP_SLVERR     2'h2

`endif

// *** dv/gpes_event_monitor.sv ***
// Port checker of the shared event block
`default_nettype none
module gpes_event_monitor (
    // Register bus
    input wire logic        core_clk, arst_n, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,
    // Event and pin side
    input wire logic [2:0]  port_event_req, port_notify_allow,
    input wire logic        pin7_func_sel, pin7_gpio_out, pin7_gpio_oe,
    input wire logic        pin7_out, pin7_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [3:0]  ctl_q, wd_q; // Control copy, last write data
    logic [11:0] wa_q, ra_q;  // Last write and read address
    logic        bv_q;        // Response valid at the last edge
    // Remember what the bus carried
    always_ff @(posedge core_clk) begin
        if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[3:0];
        if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
    end
    // Control copy follows each completed write to the control register, lagging one edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= 4'h0;
            bv_q  <= 1'b0;
        end else begin
            bv_q <= s_axi_bvalid;
            if (s_axi_bvalid && !bv_q && wa_q == 12'h450)
                ctl_q <= wd_q;
        end
    end
    chk_alt_drive: assert property (pin7_func_sel |-> pin7_oe)
        else $error("pin 7 undriven");
    chk_gpio_pass: assert property (!pin7_func_sel |->
        pin7_oe == pin7_gpio_oe && pin7_out == pin7_gpio_out)
        else $error("gpio passthrough");
    chk_notify_mask: assert property (!s_axi_bvalid |->
        port_notify_allow == (port_event_req & ~ctl_q[3:1]))
        else $error("notify mask");
    chk_event_level: assert property (!s_axi_bvalid
        && !$past(s_axi_bvalid) && pin7_func_sel |-> pin7_out ==
        (ctl_q[0] ~^ |($past(port_event_req) & ctl_q[3:1])))
        else $error("event level");
    chk_status_enabled: assert property (s_axi_rvalid
        && ra_q == 12'h454 |->
        (s_axi_rdata & {28'h0, ~ctl_q[3:1], 1'b1}) == 32'h0)
        else $error("status when disabled");
    chk_status_live: assert property ($rose(s_axi_rvalid)
        && ra_q == 12'h454 && !s_axi_bvalid && !$past(s_axi_bvalid) |->
        s_axi_rdata[3:1] == ($past(port_event_req, 2) & ctl_q[3:1]))
        else $error("status level");
endmodule
bind gpes_event gpes_event_monitor u_gpes_event_monitor (.*);
`default_nettype wire

// *** dv/gpes_host_model.sv ***
// Host platform event input watching pin 7
`default_nettype none
module gpes_host_model (
    input  wire logic pin7_out, pin7_oe, active_high,
    output var logic  event_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Seen only while driven at the active level
    always_comb event_seen = pin7_oe && (pin7_out == active_high);
endmodule
`default_nettype wire

// *** dv/gpes_event_tb.sv ***
// Testbench of the shared event block
`default_nettype none
module gpes_event_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = '0, arst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
    logic s_axi_bready = '1, s_axi_arvalid = '0, s_axi_rready = '1, pol = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, rd_v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] port_event_req = '0, en;
    logic pin7_func_sel = '1, pin7_gpio_out = '0, pin7_gpio_oe = '0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, pin7_out, pin7_oe, event_seen;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] port_notify_allow;
    logic [1:0] rsp;
    int err_total = 0, tests_run = 0;
    gpes_event u_gpes_event (.*);
    gpes_host_model u_gpes_host_model (.active_high(pol), .*);
    initial forever #20 core_clk = ~core_clk;
    // Compare and count
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One bus write or read, bounded wait on the response
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        if (w) begin
            {s_axi_awaddr, s_axi_wdata} <= {a, d};
            {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        end else begin
            {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        end
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 20);
        rsp = w ? s_axi_bresp : s_axi_rresp;
        rd_v = s_axi_rdata;
        if (n == 20) begin
            err_total++;
            final_report();
        end
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        xfer(1'b0, 12'h450, '0);
        check("ctl reset", rd_v, 32'h0);
        check("idle pin", pin7_out, 32'h1);
        port_event_req <= 3'h7;
        // Each port alone, both polarities, then none enabled
        for (int i = 0; i < 8; i++) begin
            en = 3'h1 << (i >> 1);
            pol <= i[0];
            xfer(1'b1, 12'h450, {28'h0, en, i[0]});
            xfer(1'b0, 12'h454, '0);
            check("status", rd_v, {28'h0, en, 1'b0});
            check("notify", port_notify_allow, 3'h7 & ~en);
            check("pin", pin7_out, {31'h0, (en != 3'h0) ~^ i[0]});
            check("host", event_seen, en != 3'h0);
        end
        $display("port test done");
        port_event_req <= 3'h4;
        xfer(1'b1, 12'h454, 32'hE);
        check("sts write resp", rsp, 32'h0);
        xfer(1'b0, 12'h450, '0);
        check("sts read only", rd_v, 32'h1);
        xfer(1'b1, 12'h450, 32'hE);
        xfer(1'b0, 12'h454, '0);
        check("multi", {rsp, rd_v[3:0], pin7_out}, 32'h10);
        xfer(1'b0, 12'h458, '0);
        check("unmapped resp", rsp, 32'h2);
        check("unmapped data", rd_v, 32'h0);
        xfer(1'b1, 12'h458, 32'hF);
        check("unmapped wr resp", rsp, 32'h2);
        pin7_func_sel <= 1'b0;
        pin7_gpio_out <= 1'b1;
        @(posedge core_clk);
        check("gpio", {pin7_oe, pin7_out}, 32'h1);
        pin7_gpio_oe  <= 1'b1;
        pin7_gpio_out <= 1'b0;
        @(posedge core_clk);
        check("gpio oe", {pin7_oe, pin7_out}, 32'h2);
        $display("pin test done");
        final_report();
    end
endmodule
`default_nettype wire
